/* File: shared/timer_defines.vh */
// register map, field layout, reset values and mode codes of the timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// byte offsets on the register bus
`define TMR_CTRL_OFS 8'h00
`define TMR_COUNT_OFS 8'h04
`define TMR_RELOAD_OFS 8'h08
`define TMR_PWM_OFS 8'h0C
`define TMR_STATUS_OFS 8'h10

// control word fields
`define TMR_CTRL_EN_BIT 0
`define TMR_CTRL_MODE_LSB 1
`define TMR_CTRL_MODE_MSB 3
`define TMR_CTRL_SCALE_LSB 4
`define TMR_CTRL_SCALE_MSB 6
`define TMR_CTRL_POL_BIT 7
`define TMR_CTRL_OE_BIT 8
`define TMR_CTRL_WIDTH 9

// reset values
`define TMR_CTRL_RST 9'h000
`define TMR_COUNT_RST 16'h0000
`define TMR_RELOAD_RST 16'hFFFF
`define TMR_PWM_RST 16'h0000

// count value loaded at every reload
`define TMR_RESTART 16'h0001

// operating modes
`define TMR_MODE_PWM 3'h0
`define TMR_MODE_CAPTURE 3'h1
`define TMR_MODE_COMPARE 3'h2
`define TMR_MODE_GATED 3'h3

// bus responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: hdl/tick_divider.v */
// prescaler: one-cycle count tick every 2**scale clocks while running
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter SCALE_W = 3,
    parameter CNT_W = 7
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire [SCALE_W-1:0] scale,
    output reg tick
);
    reg [CNT_W-1:0] div_reg;
    wire [CNT_W-1:0] limit;

    // divide by 1, 2, 4 ... 128
    assign limit = ~({CNT_W{1'b1}} << scale);

    always @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            // restart from zero so the first period is whole
            div_reg <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (div_reg == limit) begin
            div_reg <= {CNT_W{1'b0}};
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule // tick_divider
`default_nettype wire

/* File: hdl/input_edges.v */
// timer input sampler: level, selected edge and gate release pulses
`timescale 1ns/1ps
`default_nettype none
module input_edges (
    input wire aclk,
    input wire aresetn,
    input wire pin_in,
    input wire polarity,
    output reg level,
    output wire sel_edge,
    output wire gate_active,
    output wire gate_leave
);
    reg prev_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            level <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            level <= pin_in;
            prev_reg <= level;
        end
    end

    // polarity 1 picks the rising edge and a high gate
    assign sel_edge = polarity ? (level & ~prev_reg) : (~level & prev_reg);
    assign gate_active = (level == polarity);
    assign gate_leave = (prev_reg == polarity) && (level != polarity);
endmodule // input_edges
`default_nettype wire

/* File: hdl/timer_modes.v */
// 16-bit timer: pwm, capture, compare and gated modes behind axi4-lite
// Contract
// - pwm mode toggles output at match value
// - pwm reload: interrupt, count to 0001, continue
// - polarity 1: start high, low at match
// - polarity 0: start low, high at match
// - pwm start count only for first period
// - capture edge copies count, interrupts, keeps counting
// - polarity selects capture edge direction
// - capture mode also interrupts at reload
// - compare match interrupts, count not reloaded
// - compare match inverts output when enabled
// - compare counter wraps ffff to 0000
// - gated counts only while input active
// - gated interrupts on input release, reload
// - gated reload to 0001, resume if active
// - gated reload inverts output when enabled
// - gated start count only for first pass
// - compare counts prescaled system clock only
// - prescaler divides by 1 to 128
// - counter is 16-bit up counter
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module timer_modes #(
    parameter ADDR_W = 8,
    parameter CNT_W = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer_in,
    output reg timer_out,
    output reg timer_irq
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    reg [`TMR_CTRL_WIDTH-1:0] ctrl_reg;
    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] reload_reg;
    reg [CNT_W-1:0] pwm_reg;
    reg cap_pend_reg;
    reg was_en_reg;

    wire enable;
    wire [2:0] mode;
    wire [2:0] scale;
    wire output_polarity_bit;
    wire out_en;
    wire tick;
    wire in_level;
    wire sel_edge;
    wire gate_active;
    wire gate_leave;
    wire at_reload;
    wire at_match;
    wire [CNT_W-1:0] count_inc;

    assign enable = ctrl_reg[`TMR_CTRL_EN_BIT];
    assign mode = ctrl_reg[`TMR_CTRL_MODE_MSB:`TMR_CTRL_MODE_LSB];
    assign scale = ctrl_reg[`TMR_CTRL_SCALE_MSB:`TMR_CTRL_SCALE_LSB];
    assign output_polarity_bit = ctrl_reg[`TMR_CTRL_POL_BIT];
    assign out_en = ctrl_reg[`TMR_CTRL_OE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // prescaler and input sampling
    tick_divider #(
        .SCALE_W(3),
        .CNT_W(7)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(enable),
        .scale(scale),
        .tick(tick)
    );

    input_edges u_edges (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(timer_in),
        .polarity(output_polarity_bit),
        .level(in_level),
        .sel_edge(sel_edge),
        .gate_active(gate_active),
        .gate_leave(gate_leave)
    );

    assign at_reload = (count_reg == reload_reg);
    assign at_match = (count_reg == pwm_reg);
    // natural 16-bit overflow gives the ffff to 0000 wrap
    assign count_inc = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    reg aw_full_reg;
    reg w_full_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire do_write;
    wire wr_ctrl;
    wire wr_count;
    wire wr_reload;
    wire wr_pwm;
    reg wr_hit;
    reg [31:0] rd_word;
    reg rd_hit;

    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    assign s_axi_arready = ~s_axi_rvalid;
    // one write at a time: the response must drain before the next
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_ctrl = do_write && (aw_addr_reg == `TMR_CTRL_OFS);
    assign wr_count = do_write && (aw_addr_reg == `TMR_COUNT_OFS);
    assign wr_reload = do_write && (aw_addr_reg == `TMR_RELOAD_OFS);
    assign wr_pwm = do_write && (aw_addr_reg == `TMR_PWM_OFS);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = din[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] ctrl_wr;
    wire [31:0] count_wr;
    wire [31:0] reload_wr;
    wire [31:0] pwm_wr;
    assign ctrl_wr = merge({{(32-`TMR_CTRL_WIDTH){1'b0}}, ctrl_reg}, w_data_reg, w_strb_reg);
    assign count_wr = merge({16'h0000, count_reg}, w_data_reg, w_strb_reg);
    assign reload_wr = merge({16'h0000, reload_reg}, w_data_reg, w_strb_reg);
    assign pwm_wr = merge({16'h0000, pwm_reg}, w_data_reg, w_strb_reg);

    always @* begin
        wr_hit = 1'b0;
        if (aw_addr_reg == `TMR_CTRL_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr_reg == `TMR_COUNT_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr_reg == `TMR_RELOAD_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr_reg == `TMR_PWM_OFS) begin
            wr_hit = 1'b1;
        end else if (aw_addr_reg == `TMR_STATUS_OFS) begin
            // status is read only; the write is dropped but accepted
            wr_hit = 1'b1;
        end
    end

    always @* begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (s_axi_araddr == `TMR_CTRL_OFS) begin
            rd_word = {{(32-`TMR_CTRL_WIDTH){1'b0}}, ctrl_reg};
        end else if (s_axi_araddr == `TMR_COUNT_OFS) begin
            rd_word = {16'h0000, count_reg};
        end else if (s_axi_araddr == `TMR_RELOAD_OFS) begin
            rd_word = {16'h0000, reload_reg};
        end else if (s_axi_araddr == `TMR_PWM_OFS) begin
            rd_word = {16'h0000, pwm_reg};
        end else if (s_axi_araddr == `TMR_STATUS_OFS) begin
            rd_word = {28'h0000000, cap_pend_reg, gate_active, in_level, timer_out};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= {ADDR_W{1'b0}};
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `AXI_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer core
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `TMR_CTRL_RST;
            count_reg <= `TMR_COUNT_RST;
            reload_reg <= `TMR_RELOAD_RST;
            pwm_reg <= `TMR_PWM_RST;
            cap_pend_reg <= 1'b0;
            was_en_reg <= 1'b0;
            timer_out <= 1'b0;
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= 1'b0;
            was_en_reg <= enable;
            if (!enable) begin
                // idle level follows polarity, so the run starts from it
                timer_out <= output_polarity_bit;
                cap_pend_reg <= 1'b0;
            end else begin
                case (mode)
                    `TMR_MODE_PWM: begin
                        if (tick) begin
                            if (at_reload) begin
                                count_reg <= `TMR_RESTART;
                                timer_out <= output_polarity_bit;
                                timer_irq <= 1'b1;
                            end else begin
                                count_reg <= count_inc;
                                if (at_match) begin
                                    timer_out <= ~output_polarity_bit;
                                end
                            end
                        end
                    end
                    `TMR_MODE_CAPTURE: begin
                        // edges faster than the tick are held until it comes
                        if (sel_edge) begin
                            cap_pend_reg <= 1'b1;
                        end
                        if (tick) begin
                            count_reg <= at_reload ? `TMR_RESTART : count_inc;
                            if (cap_pend_reg || sel_edge) begin
                                pwm_reg <= count_reg;
                                cap_pend_reg <= 1'b0;
                                timer_irq <= 1'b1;
                            end else if (at_reload) begin
                                timer_irq <= 1'b1;
                            end
                        end
                    end
                    `TMR_MODE_COMPARE: begin
                        if (tick) begin
                            count_reg <= count_inc;
                            if (at_reload) begin
                                timer_irq <= 1'b1;
                                if (out_en) begin
                                    timer_out <= ~timer_out;
                                end
                            end
                        end
                    end
                    `TMR_MODE_GATED: begin
                        if (gate_leave) begin
                            timer_irq <= 1'b1;
                        end
                        if (tick && gate_active) begin
                            if (at_reload) begin
                                count_reg <= `TMR_RESTART;
                                timer_irq <= 1'b1;
                                if (out_en) begin
                                    timer_out <= ~timer_out;
                                end
                            end else begin
                                count_reg <= count_inc;
                            end
                        end
                    end
                    default: begin
                        // unused mode codes hold the count
                        count_reg <= count_reg;
                    end
                endcase
            end
            // software writes land after the core so they win over it in the same cycle, except a pwm write that meets a capture
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_wr[`TMR_CTRL_WIDTH-1:0];
            end
            if (wr_count) begin
                count_reg <= count_wr[CNT_W-1:0];
            end
            if (wr_reload) begin
                reload_reg <= reload_wr[CNT_W-1:0];
            end
            // a capture in the same cycle beats a software write
            if (wr_pwm && !(enable && mode == `TMR_MODE_CAPTURE && tick
                    && (cap_pend_reg || sel_edge))) begin
                pwm_reg <= pwm_wr[CNT_W-1:0];
            end
        end
    end
endmodule // timer_modes
`default_nettype wire

/* File: dv/timer_modes_checker.sv */
// port-level assertions for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module timer_modes_checker #(
    parameter ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic timer_in,
    input wire logic timer_out,
    input wire logic timer_irq
);
    //////////////////////////////
    logic [8:0] ctl_reg;
    logic [3:0] age_reg;
    wire en = ctl_reg[0];
    wire pol = ctl_reg[7];
    wire oe = ctl_reg[8];
    wire [2:0] md = ctl_reg[3:1];
    wire st = age_reg > 4'h3;
    wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // only tracks writes whose address and data are taken together
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= 9'h000;
            age_reg <= 4'h0;
        end else if (aw_w && s_axi_awaddr == `TMR_CTRL_OFS) begin
            ctl_reg <= s_axi_wdata[8:0];
            age_reg <= 4'h0;
        end else if (age_reg != 4'hF) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    //////////////////////////////
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_irq_pulse; timer_irq |=> !timer_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too wide");
    property p_idle_out; st && !en |-> timer_out == pol; endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle level");
    property p_idle_quiet; st && !en |-> !timer_irq; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("irq while off");
    property p_pwm_rl; st && en && md == `TMR_MODE_PWM && timer_irq |-> ##[0:1] timer_out == pol;
    endproperty
    a_pwm_rl: assert property (p_pwm_rl) else $error("pwm reload level");
    property p_quiet_out;
        st && en && !oe && (md == `TMR_MODE_COMPARE || md == `TMR_MODE_GATED) |-> $stable(timer_out);
    endproperty
    a_quiet_out: assert property (p_quiet_out) else $error("output moved");
    property p_gate_leave;
        st && en && md == `TMR_MODE_GATED && $past(timer_in) == pol && timer_in != pol
            |-> ##[1:4] timer_irq;
    endproperty
    a_gate_leave: assert property (p_gate_leave) else $error("no release irq");
    property p_wr_resp; aw_w |-> ##2 s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("late write response");
    property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("late read response");
    c_pwm: cover property (en && md == `TMR_MODE_PWM && timer_irq);
    c_cap: cover property (en && md == `TMR_MODE_CAPTURE && timer_irq);
    c_gate: cover property (en && md == `TMR_MODE_GATED && timer_irq);
endmodule // timer_modes_checker
bind timer_modes timer_modes_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .timer_in(timer_in), .timer_out(timer_out),
    .timer_irq(timer_irq));
`default_nettype wire

/* File: dv/pin_side.sv */
// far side of the timer pins: input driver and output edge counter
`timescale 1ns/1ps
`default_nettype none
module pin_side (
    input wire logic aclk,
    input wire logic level_cmd,
    input wire logic timer_out,
    output logic timer_in,
    output int out_edges
);
    initial begin
        timer_in = 1'b0;
        out_edges = 0;
    end
    // the pin moves just after an edge, like a synchronous source
    always @(posedge aclk) begin
        timer_in <= level_cmd;
    end
    // counted as the level moves, so a read at the next edge already sees it
    always @(timer_out) begin
        out_edges <= out_edges + 1;
    end
endmodule // pin_side
`default_nettype wire

/* File: dv/timer_modes_test.sv */
// self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module timer_modes_test;
    typedef struct {logic pol; logic [2:0] sc; logic [15:0] st, rl, pw; int per, hi;} row_t;
    row_t rows[4] = '{'{0, 0, 1, 8, 3, 8, 5}, '{1, 0, 7, 8, 3, 8, 3},
        '{0, 2, 1, 5, 1, 20, 16}, '{1, 7, 1, 3, 2, 384, 256}};
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin_level;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, timer_in, timer_out, timer_irq;
    int miscompares, n_tests, out_edges;
    timer_modes #(.ADDR_W(8), .CNT_W(16)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_in(timer_in),
        .timer_out(timer_out), .timer_irq(timer_irq));
    pin_side pins (.aclk(aclk), .level_cmd(pin_level), .timer_out(timer_out),
        .timer_in(timer_in), .out_edges(out_edges));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    //////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    function automatic logic [31:0] ctl(input logic en, input logic [2:0] md,
                                        input logic [2:0] sc, input logic pol, input logic oe);
        return {23'h0, oe, pol, sc, md, en};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int k;
        @(posedge aclk);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            {awvalid, wvalid, bready} <= 3'h7;
        end else begin
            araddr <= a;
            {arvalid, rready} <= 2'h3;
        end
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            if (bready && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            if (rready && rvalid) begin
                r = rresp;
                q = rdata;
                rready <= 1'b0;
                break;
            end
        end
        if (k == 40) begin
            chk("bus_wait", 32'h1, 32'h0);
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, a, d, q, r);
        chk("bresp", `AXI_RESP_OKAY, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic [1:0] r;
        bus(1'b0, a, 32'h0, q, r);
        chk("rresp", `AXI_RESP_OKAY, r);
    endtask
    // cycles until the next interrupt, and how many of them had the output high
    task automatic wirq(input int lim, output int c, output int h);
        c = 0;
        h = 0;
        do begin
            @(posedge aclk);
            c++;
            if (timer_out === 1'b1) h++;
        end while (timer_irq !== 1'b1 && c < lim);
        if (timer_irq !== 1'b1) begin
            chk("irq_wait", 32'h1, 32'h0);
            complete_run();
        end
    endtask
    //////////////////////////////
    initial begin
        int i, c, h, e;
        logic [31:0] q, q2;
        logic [1:0] r;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, pin_level} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd(8'(4 * i), q);
            chk("reg_rst", (i == 2) ? 32'h0000FFFF : 32'h0, q);
        end
        bus(1'b0, 8'h14, 32'h0, q, r);
        chk("rd_unmap", {q[29:0], r}, 32'h2);
        bus(1'b1, 8'h14, 32'h5, q, r);
        chk("wr_unmap", `AXI_RESP_SLVERR, r);
        for (i = 0; i < 4; i++) begin
            wr(`TMR_CTRL_OFS, ctl(0, `TMR_MODE_PWM, rows[i].sc, rows[i].pol, 0));
            wr(`TMR_COUNT_OFS, 32'(rows[i].st));
            wr(`TMR_PWM_OFS, 32'(rows[i].pw));
            wr(`TMR_RELOAD_OFS, 32'(rows[i].rl));
            chk("pwm_start", 32'(rows[i].pol), timer_out);
            wr(`TMR_CTRL_OFS, ctl(1, `TMR_MODE_PWM, rows[i].sc, rows[i].pol, 0));
            wirq(2000, c, h);
            e = out_edges;
            wirq(2000, c, h);
            chk("pwm_period", 32'(rows[i].per), 32'(c));
            chk("pwm_high", 32'(rows[i].hi), 32'(h));
            chk("pwm_edges", 32'h2, 32'(out_edges - e));
        end
        wr(`TMR_CTRL_OFS, ctl(0, `TMR_MODE_CAPTURE, 0, 1, 0));
        wr(`TMR_COUNT_OFS, 32'h1);
        wr(`TMR_RELOAD_OFS, 32'h100);
        wr(`TMR_PWM_OFS, 32'h0);
        wr(`TMR_CTRL_OFS, ctl(1, `TMR_MODE_CAPTURE, 0, 1, 0));
        repeat (20) @(posedge aclk);
        pin_level <= 1'b1;
        wirq(20, c, h);
        rd(`TMR_PWM_OFS, q);
        rd(`TMR_COUNT_OFS, q2);
        chk("cap_run", 32'h1, 32'(q != 0 && q2 > q));
        wr(`TMR_PWM_OFS, 32'h0);
        pin_level <= 1'b0;
        wirq(400, c, h);
        chk("cap_fall", 32'h1, 32'(c > 20));
        rd(`TMR_PWM_OFS, q);
        chk("cap_reload", 32'h0, q);
        wr(`TMR_CTRL_OFS, ctl(0, `TMR_MODE_COMPARE, 0, 0, 1));
        wr(`TMR_COUNT_OFS, 32'hFFFD);
        wr(`TMR_RELOAD_OFS, 32'h2);
        wr(`TMR_CTRL_OFS, ctl(1, `TMR_MODE_COMPARE, 0, 0, 1));
        pin_level <= 1'b1;
        wirq(40, c, h);
        wirq(70000, c, h);
        chk("cmp_wrap", 32'h10000, 32'(c));
        chk("cmp_toggle", 32'h1, 32'(h > 65530));
        rd(`TMR_COUNT_OFS, q);
        chk("cmp_run", 32'h1, 32'(q > 2 && q < 32'h40));
        chk("cmp_back", 32'h0, timer_out);
        wr(`TMR_CTRL_OFS, ctl(0, `TMR_MODE_COMPARE, 0, 0, 0));
        // restart below the compare value so a match falls inside the wait
        wr(`TMR_COUNT_OFS, 32'h1);
        wr(`TMR_CTRL_OFS, ctl(1, `TMR_MODE_COMPARE, 0, 0, 0));
        repeat (12) @(posedge aclk);
        chk("cmp_quiet", 32'h0, timer_out);
        pin_level <= 1'b0;
        wr(`TMR_CTRL_OFS, ctl(0, `TMR_MODE_GATED, 0, 1, 1));
        wr(`TMR_COUNT_OFS, 32'h5);
        wr(`TMR_RELOAD_OFS, 32'h14);
        wr(`TMR_CTRL_OFS, ctl(1, `TMR_MODE_GATED, 0, 1, 1));
        repeat (20) @(posedge aclk);
        rd(`TMR_COUNT_OFS, q);
        chk("gate_hold", 32'h5, q);
        pin_level <= 1'b1;
        wirq(40, c, h);
        wirq(40, c, h);
        chk("gate_period", 32'h14, 32'(c));
        chk("gate_low", 32'h1, 32'(h < 2));
        rd(`TMR_COUNT_OFS, q);
        chk("gate_out", 32'h1, timer_out);
        pin_level <= 1'b0;
        wirq(10, c, h);
        rd(`TMR_COUNT_OFS, q);
        repeat (10) @(posedge aclk);
        rd(`TMR_COUNT_OFS, q2);
        chk("gate_stop", q, q2);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TMR_RELOAD_OFS, q);
        chk("rst_reload", 32'h0000FFFF, q);
        rd(`TMR_COUNT_OFS, q);
        chk("rst_count", 32'h0, q);
        chk("rst_out", 32'h0, timer_out);
        complete_run();
    end
endmodule // timer_modes_test
`default_nettype wire
